// *** verilog/abd_pkg.sv ***
// Purpose: Shared constants and carriers for the and/branch/bit-clear slice.
// Assumes: One 100 MHz clock, four quarter phases per instruction cycle.
`default_nettype none
package abd_pkg;
	localparam int PC_W = 21;
	localparam int DADDR_W = 12;
	localparam logic [3:0] OP_AND_HI = 4'h1;
	localparam logic [1:0] OP_AND_SUB = 2'h1;
	localparam logic [3:0] OP_BCLR_HI = 4'h9;
	localparam logic [7:0] OP_BR_CARRY = 8'hE2;
	localparam logic [7:0] OP_BR_NEG = 8'hE6;
	localparam logic [7:0] IDX_LIMIT = 8'h5F;
	localparam logic [7:0] ACC_SPLIT = 8'h60;
	localparam logic [3:0] ACC_HI_BANK = 4'hF;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int SIGN_BIT = 7;

	typedef enum logic [1:0] {
		Q1 = 2'b00,
		Q2 = 2'b01,
		Q3 = 2'b10,
		Q4 = 2'b11
	} abd_quarter_e;

	typedef struct packed {
		logic                 wr;
		logic                 rd;
		logic                 indexed;
		logic [DADDR_W-1:0]   addr;
		logic [7:0]           wdata;
	} abd_dmem_s;

	typedef struct packed {
		logic sign;
		logic zero;
		logic carry;
	} abd_flags_s;
endpackage : abd_pkg
`default_nettype wire

// *** verilog/abd_core.sv ***
// Purpose: Decode and execute for AND-with-file, two branches and bit clear.
// Assumes: Instruction word and memory read data are on the mclk domain.
// Notes: Other opcodes pass through as one-cycle no-operations here.
`timescale 1ns/100ps
`default_nettype none
module abd_core (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic [15:0]             instr,
	input  wire logic                    ext_set_en,
	input  wire logic [3:0]              bank_pointer,
	input  wire logic [7:0]              dmem_rdata,
	input  wire logic                    carry_in,
	output logic [abd_pkg::PC_W-1:0]     program_counter,
	output abd_pkg::abd_dmem_s           dmem,
	output logic [7:0]                   accum,
	output abd_pkg::abd_flags_s          flags,
	output logic                         flush,
	output abd_pkg::abd_quarter_e        quarter
);
	abd_pkg::abd_quarter_e    q_reg;
	abd_pkg::abd_quarter_e    q_next;
	logic [15:0]              ir_reg;
	logic [7:0]               opnd_reg;
	logic [7:0]               res_reg;
	logic                     take_reg;
	logic                     take_next;
	logic                     flush_reg;
	logic                     flush_next;
	logic [abd_pkg::PC_W-1:0] pc_seq;
	logic [abd_pkg::PC_W-1:0] pc_target;

	// Access bank, banked or indexed address for a file operand.
	function automatic logic [abd_pkg::DADDR_W:0] map_addr(
		input logic a, input logic [7:0] f,
		input logic [3:0] bp, input logic ext);
		logic [abd_pkg::DADDR_W:0] r;
		r = {1'b0, bp, f};
		if (!a) begin
			if (ext && f <= abd_pkg::IDX_LIMIT)
				r = {1'b1, 4'h0, f};
			else if (f < abd_pkg::ACC_SPLIT)
				r = {1'b0, 4'h0, f};
			else
				r = {1'b0, abd_pkg::ACC_HI_BANK, f};
		end
		return r;
	endfunction : map_addr

	// AND-with-file opcode test, used on the fetched and the held word.
	function automatic logic is_and_op(
		input logic [15:0] w);
		return w[15:12] == abd_pkg::OP_AND_HI &&
			w[11:10] == abd_pkg::OP_AND_SUB;
	endfunction : is_and_op

	// Bit-clear opcode test, used on the fetched and the held word.
	function automatic logic is_bclr_op(
		input logic [15:0] w);
		return w[15:12] == abd_pkg::OP_BCLR_HI;
	endfunction : is_bclr_op

	// Result of the third quarter: a cleared bit or the AND with the
	// accumulator. The write data and the held result both use it, so the
	// file write never carries the byte of an earlier instruction.
	function automatic logic [7:0] alu_result(
		input logic [15:0] w, input logic [7:0] acc,
		input logic [7:0] opnd);
		logic [7:0] r;
		if (is_bclr_op(w))
			r = opnd & ~(8'h01 << w[11:9]);
		else
			r = acc & opnd;
		return r;
	endfunction : alu_result

	function automatic logic [abd_pkg::PC_W-1:0] branch_offset(
		input logic [7:0] n);
		return {{(abd_pkg::PC_W-9){n[7]}}, n, 1'b0};
	endfunction : branch_offset

	wire logic is_and     = is_and_op(instr);
	wire logic is_bclr    = is_bclr_op(instr);
	wire logic is_bc      = instr[15:8] == abd_pkg::OP_BR_CARRY;
	wire logic is_bn      = instr[15:8] == abd_pkg::OP_BR_NEG;
	wire logic ir_and     = is_and_op(ir_reg);
	wire logic ir_bclr    = is_bclr_op(ir_reg);
	wire logic ir_to_file = (ir_and && ir_reg[9]) || ir_bclr;
	wire logic [abd_pkg::DADDR_W:0] ea =
		map_addr(instr[8], instr[7:0], bank_pointer, ext_set_en);

	assign q_next = abd_pkg::abd_quarter_e'(q_reg + 2'b01);

	// carry comes straight from the flag input: the held copy is
	// still at its reset value when the first word after reset is decoded.
	assign take_next = !flush_reg && ((is_bc && carry_in) ||
		(is_bn && flags.sign));

	// only the fourth quarter moves the flush flag.
	assign flush_next = (q_reg == abd_pkg::Q4) ?
		(take_reg && !flush_reg) : flush_reg;

	// both candidates for the next instruction address.
	assign pc_seq = program_counter + abd_pkg::PC_STEP;
	assign pc_target = pc_seq + branch_offset(ir_reg[7:0]);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			q_reg <= abd_pkg::Q1;
		else
			q_reg <= q_next;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ir_reg <= 16'h0000;
		else if (q_reg == abd_pkg::Q1)
			ir_reg <= flush_reg ? 16'h0000 : instr;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dmem <= '0;
		end else begin
			dmem.rd <= 1'b0;
			dmem.wr <= 1'b0;
			if (q_reg == abd_pkg::Q1 && !flush_reg && (is_and || is_bclr)) begin
				dmem.rd <= 1'b1;
				{dmem.indexed, dmem.addr} <= ea;
			end
			// file destination write.
			// The strobe rises at the third-quarter edge so that it stands
			// through the fourth quarter and the byte lands on its edge.
			if (q_reg == abd_pkg::Q3 && !flush_reg && ir_to_file) begin
				dmem.wr <= 1'b1;
				dmem.wdata <= alu_result(ir_reg, accum, opnd_reg);
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			opnd_reg <= abd_pkg::BYTE_ZERO;
		else if (q_reg == abd_pkg::Q2)
			opnd_reg <= dmem_rdata;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			res_reg <= abd_pkg::BYTE_ZERO;
		else if (q_reg == abd_pkg::Q3)
			res_reg <= alu_result(ir_reg, accum, opnd_reg);
	end

	// only sign and zero follow the AND result.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flags <= '0;
		end else begin
			flags.carry <= carry_in;
			if (q_reg == abd_pkg::Q4 && !flush_reg && ir_and) begin
				flags.sign <= res_reg[abd_pkg::SIGN_BIT];
				flags.zero <= res_reg == abd_pkg::BYTE_ZERO;
			end
		end
	end

	// accumulator destination, in the fourth quarter.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			accum <= abd_pkg::BYTE_ZERO;
		else if (q_reg == abd_pkg::Q4 && !flush_reg && ir_and && !ir_reg[9])
			accum <= res_reg;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			take_reg <= 1'b0;
		else if (q_reg == abd_pkg::Q1)
			take_reg <= take_next;
	end

	// target is incremented address plus doubled signed offset.
	// the flush cycle holds the counter while the target is fetched
	// otherwise the instruction at the target would be skipped.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			program_counter <= abd_pkg::PC_RESET;
		else if (q_reg == abd_pkg::Q4 && !flush_reg) begin
			if (take_reg)
				program_counter <= pc_target;
			else
				program_counter <= pc_seq;
		end
	end

	// taken branch adds a flush cycle.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			flush_reg <= 1'b0;
		else
			flush_reg <= flush_next;
	end

	// The outputs load the next internal state, so quarter and flush line
	// up with the memory strobes that they describe.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			quarter <= abd_pkg::Q1;
		else
			quarter <= q_next;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			flush <= 1'b0;
		else
			flush <= flush_next;
	end
endmodule : abd_core
`default_nettype wire

// *** testbench/abd_core_properties.sv ***
// Purpose: Port checks for abd_core.
// Assumes: Quarter output is aligned with the memory strobes.
// Notes: Timing, even counter and indexed address range only; data values are judged by the bench.
`timescale 1ns/100ps
`default_nettype none
module abd_core_properties (
	input wire logic                     mclk,
	input wire logic                     rst,
	input wire logic [abd_pkg::PC_W-1:0] program_counter,
	input wire abd_pkg::abd_dmem_s       dmem,
	input wire logic                     flush,
	input wire abd_pkg::abd_quarter_e    quarter
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_flush4;
		flush [*4] ##1 !flush;
	endsequence
	a_rd_in_q2: assert property (dmem.rd |-> quarter == abd_pkg::Q2)
		else $error("read outside second quarter");
	a_wr_in_q4: assert property (dmem.wr |-> quarter == abd_pkg::Q4)
		else $error("write outside fourth quarter");
	a_rmw_order: assert property (dmem.wr |-> $past(dmem.rd, 2))
		else $error("write without read two cycles before");
	a_addr_hold: assert property (dmem.rd |=> $stable(dmem.addr) [*2])
		else $error("address moved between read and write");
	a_flush_quiet: assert property (flush |-> !dmem.rd && !dmem.wr)
		else $error("memory access during flush");
	a_flush_len: assert property ($rose(flush) |-> s_flush4)
		else $error("flush not one instruction cycle");
	a_pc_even: assert property (!program_counter[0])
		else $error("odd program counter");
	a_idx_low: assert property (dmem.rd && dmem.indexed |->
		dmem.addr <= 12'h05F) else $error("indexed address too high");
endmodule : abd_core_properties
`default_nettype wire

// *** testbench/abd_mem_model.sv ***
// Purpose: Program and data memory beside abd_core.
// Assumes: Both memories answer combinationally.
// Notes: Idle read data is inverted so a stale byte never passes.
`timescale 1ns/100ps
`default_nettype none
module abd_mem_model (
	input wire logic                     mclk,
	input wire logic [abd_pkg::PC_W-1:0] program_counter,
	input wire abd_pkg::abd_dmem_s       dmem,
	output logic [15:0]                  instr,
	output logic [7:0]                   dmem_rdata
);
	logic [15:0] prog [0:255];
	logic [7:0]  ram [0:4095];
	assign instr = prog[program_counter[8:1]];
	assign dmem_rdata = dmem.rd ? ram[dmem.addr] : ~ram[dmem.addr];
	always @(posedge mclk) if (dmem.wr) ram[dmem.addr] <= dmem.wdata;
endmodule : abd_mem_model
`default_nettype wire

// *** testbench/and_branch_bitclear_decode_tb.sv ***
// Purpose: Random and corner runs of abd_core.
// Assumes: Memory model beside the core.
// Notes: Strobe and address are checked one cycle after reset; other outcomes are read from memory, flag and accumulator ports after the run settles.
`timescale 1ns/100ps
`default_nettype none
module and_branch_bitclear_decode_tb;
	logic mclk = 0, rst = 1, ext_set_en = 0, carry_in = 0;
	logic [3:0] bank_pointer = 4'h0;
	logic [15:0] instr;
	logic [7:0] dmem_rdata, accum, v, f;
	logic [abd_pkg::PC_W-1:0] program_counter;
	abd_pkg::abd_dmem_s dmem;
	abd_pkg::abd_flags_s flags;
	abd_pkg::abd_quarter_e quarter;
	logic flush, a, d, s, tk;
	logic [2:0] b;
	logic [11:0] ad;
	int seed = 77, fails = 0, total_checks = 0, n, i, j, k;
	abd_core dut_u (.mclk(mclk), .rst(rst), .instr(instr),
		.ext_set_en(ext_set_en), .bank_pointer(bank_pointer),
		.dmem_rdata(dmem_rdata), .carry_in(carry_in), .accum(accum),
		.program_counter(program_counter), .dmem(dmem), .flags(flags),
		.flush(flush), .quarter(quarter));
	abd_mem_model mem_u (.mclk(mclk), .program_counter(program_counter),
		.dmem(dmem), .instr(instr), .dmem_rdata(dmem_rdata));
	function automatic logic [11:0] ea(logic a, logic [7:0] f, logic [3:0] p);
		return a ? {p, f} : {(f < 8'h60) ? 4'h0 : 4'hF, f};
	endfunction : ea
	task chk(input string nm, input logic [20:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task results;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial forever #5 mclk = ~mclk;
	initial begin
		#20000;
		fails++;
		results();
	end
	initial begin
		for (i = 0; i < 16; i++) begin
			@(negedge mclk);
			rst = 1;
			k = i % 4;
			{d, a, b, s, ext_set_en, carry_in} = 8'($random(seed));
			bank_pointer = 4'($random(seed));
			f = (i < 2) ? 8'(8'h5F + i) : 8'($random(seed)) | 8'h40;
			v = 8'($random(seed));
			n = 4 + {$random(seed)} % 97;
			if (s) n = -n;
			for (j = 0; j < 256; j++) mem_u.prog[j] = 16'h0000;
			for (j = 0; j < 4096; j++) mem_u.ram[j] = 8'hFF;
			ad = ea(a, f, bank_pointer);
			mem_u.ram[ad] = v;
			mem_u.prog[1] = {abd_pkg::OP_BCLR_HI, 4'h0, 8'h10};
			case (k)
			0: mem_u.prog[0] = {4'h1, 2'h1, d, a, f};
			1: mem_u.prog[0] = {abd_pkg::OP_BCLR_HI, b, a, f};
			default: begin
				mem_u.prog[0] = {k == 2 ? 8'hE2 : 8'hE6, 8'(n)};
				mem_u.prog[(1 + n) & 255] = {4'h9, 4'h2, 8'h11};
			end
			endcase
			// Four cycles of reset, repeated before every run.
			repeat (4) @(negedge mclk);
			rst = 0;
			@(negedge mclk);
			chk("read", dmem.rd, k < 2);
			tk = k < 2 && ext_set_en && !a && f <= 8'h5F;
			chk("index", dmem.indexed, tk);
			if (k < 2)
				chk("addr", dmem.addr, ad);
			repeat (21) @(negedge mclk);
			tk = (k == 2) && carry_in;
			chk("flags", flags, {1'b0, k == 0, carry_in});
			case (k)
			0: chk("file", mem_u.ram[ad], d ? 8'h00 : v);
			1: chk("bit", mem_u.ram[ad], v & ~(8'h01 << b));
			default: begin
				chk("target", mem_u.ram[12'h011], tk ? 8'hFD : 8'hFF);
				chk("skip", mem_u.ram[12'h010], tk ? 8'hFF : 8'hFE);
			end
			endcase
			chk("accum", accum, 8'h00);
		end
		results();
	end
endmodule : and_branch_bitclear_decode_tb
bind abd_core abd_core_properties chk_u (.mclk(mclk), .rst(rst),
	.program_counter(program_counter), .dmem(dmem), .flush(flush),
	.quarter(quarter));
`default_nettype wire
